// *** logic/dtia_pkg.sv ***
// Behaviour
// RL1: Bit 7 reads selected endpoint toggle.
// RL2: Master selects endpoint before reading toggle.
// RL3: Writing bit 6 forces toggle DATA1.
// RL4: Writing bit 5 forces toggle DATA0.
// RL5: Master keeps selection stable with set.
// RL6: Direction bit: 0 OUT, 1 IN.
// RL7: Master uses endpoints 0,1,2,6,8 only.
// RL8: Clear: select first, then set R.
// RL9: Toggle register at 0xE683, bytes 83,E6.
// RL10: Low address byte via 0x3A, two nibbles.
// RL11: High address byte via 0x3B, two nibbles.
// RL12: Value via 0x3C, nibbles, then written.
// RL13: Read at 0x3C returns addressed register.
// RL14: Ready gates accesses; master waits.
// RL15: Active-low interrupt idles high.
// RL16: Reset restores defaults.
// RL17: Feature requests raise setup interrupt.
package dtia_pkg;
  localparam logic [5:0] DTIA_CMD_ADDR_LO = 6'h3a;
  localparam logic [5:0] DTIA_CMD_ADDR_HI = 6'h3b;
  localparam logic [5:0] DTIA_CMD_VALUE = 6'h3c;
  localparam logic [15:0] DTIA_TOG_ADDR = 16'he683;
  localparam logic [7:0] DTIA_TOG_RESET = 8'h32;
  localparam int DTIA_BIT_Q = 7;
  localparam int DTIA_BIT_S = 6;
  localparam int DTIA_BIT_R = 5;
  localparam int DTIA_BIT_IO = 4;
  localparam int DTIA_NUM_EP = 16;
  localparam logic [3:0] DTIA_BUSY_CYC = 4'h2;
  typedef enum logic [1:0] {
    DTIA_KIND_ADDR,
    DTIA_KIND_WDATA,
    DTIA_KIND_READ
  } dtia_kind_t;
endpackage

// *** logic/dtia_if.sv ***
`timescale 1ns/1ps
interface dtia_if;
  logic cmd_valid;
  dtia_pkg::dtia_kind_t cmd_kind;
  logic [5:0] cmd_addr;
  logic [3:0] cmd_nibble;
  logic ready;
  logic rd_valid;
  logic [7:0] rd_data;
  logic int_n;
  modport dev (input cmd_valid, cmd_kind, cmd_addr, cmd_nibble,
    output ready, rd_valid, rd_data, int_n);
  modport mst (output cmd_valid, cmd_kind, cmd_addr, cmd_nibble,
    input ready, rd_valid, rd_data, int_n);
endinterface

// *** logic/dtia_device.sv ***
`timescale 1ns/1ps
module dtia_device
  import dtia_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  dtia_if.dev bus,
  input wire logic setup_feature_req,
  output logic [31:0] toggle_bits
);
  logic [5:0] caddr_ff, nxt_caddr;
  logic hinib_ff, nxt_hinib;
  logic [3:0] upper_ff, nxt_upper;
  logic [15:0] iaddr_ff, nxt_iaddr;
  logic [4:0] sel_ff, nxt_sel;
  logic [31:0] tog_ff, nxt_tog;
  logic [3:0] busy_ff, nxt_busy;
  logic ready_ff, nxt_ready;
  logic rdv_ff, nxt_rdv;
  logic [7:0] rdd_ff, nxt_rdd;
  logic int_n_ff, nxt_int_n;
  logic [7:0] val;

  function automatic logic [7:0] tog_read(input logic [4:0] s,
      input logic [31:0] t);
    tog_read = {t[s], 2'b00, s}; // [RL1] [RL6]
  endfunction

  always_comb begin
    nxt_caddr = caddr_ff;
    nxt_hinib = hinib_ff;
    nxt_upper = upper_ff;
    nxt_iaddr = iaddr_ff;
    nxt_sel = sel_ff;
    nxt_tog = tog_ff;
    nxt_busy = busy_ff;
    nxt_ready = (busy_ff == 4'h0);
    nxt_rdv = 1'b0;
    nxt_rdd = rdd_ff;
    nxt_int_n = ~setup_feature_req; // [RL15] [RL17]
    val = {upper_ff, bus.cmd_nibble};
    if (busy_ff != 4'h0) begin
      nxt_busy = busy_ff - 4'h1;
    end else if (bus.cmd_valid && ready_ff) begin // [RL14]
      nxt_busy = DTIA_BUSY_CYC;
      nxt_ready = 1'b0;
      case (bus.cmd_kind)
        DTIA_KIND_ADDR: begin
          nxt_caddr = bus.cmd_addr;
          nxt_hinib = 1'b1;
        end
        DTIA_KIND_WDATA: begin
          if (hinib_ff) begin
            nxt_upper = bus.cmd_nibble;
            nxt_hinib = 1'b0;
          end else begin
            nxt_hinib = 1'b1;
            if (caddr_ff == DTIA_CMD_ADDR_LO) begin
              nxt_iaddr = {iaddr_ff[15:8], val}; // [RL10]
            end else if (caddr_ff == DTIA_CMD_ADDR_HI) begin
              nxt_iaddr = {val, iaddr_ff[7:0]}; // [RL11]
            end else if (caddr_ff == DTIA_CMD_VALUE &&
                iaddr_ff == DTIA_TOG_ADDR) begin // [RL9] [RL12]
              nxt_sel = val[4:0];
              if (val[DTIA_BIT_S]) begin
                nxt_tog[val[4:0]] = 1'b1; // [RL3]
              end else if (val[DTIA_BIT_R]) begin
                nxt_tog[val[4:0]] = 1'b0; // [RL4]
              end
            end
          end
        end
        DTIA_KIND_READ: begin
          nxt_rdv = 1'b1;
          if (bus.cmd_addr == DTIA_CMD_VALUE &&
              iaddr_ff == DTIA_TOG_ADDR) begin
            nxt_rdd = tog_read(sel_ff, tog_ff); // [RL13]
          end else begin
            nxt_rdd = 8'h00;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin // [RL16]
      caddr_ff <= 6'h00;
      hinib_ff <= 1'b1;
      upper_ff <= 4'h0;
      iaddr_ff <= 16'h0000;
      sel_ff <= DTIA_TOG_RESET[4:0];
      tog_ff <= 32'h00000000;
      busy_ff <= 4'h0;
      ready_ff <= 1'b0;
      rdv_ff <= 1'b0;
      rdd_ff <= 8'h00;
      int_n_ff <= 1'b1;
    end else if (ce) begin
      caddr_ff <= nxt_caddr;
      hinib_ff <= nxt_hinib;
      upper_ff <= nxt_upper;
      iaddr_ff <= nxt_iaddr;
      sel_ff <= nxt_sel;
      tog_ff <= nxt_tog;
      busy_ff <= nxt_busy;
      ready_ff <= nxt_ready;
      rdv_ff <= nxt_rdv;
      rdd_ff <= nxt_rdd;
      int_n_ff <= nxt_int_n;
    end
  end

  assign bus.ready = ready_ff;
  assign bus.rd_valid = rdv_ff;
  assign bus.rd_data = rdd_ff;
  assign bus.int_n = int_n_ff;
  assign toggle_bits = tog_ff;
endmodule // dtia_device

// *** logic/dtia_master.sv ***
`timescale 1ns/1ps
module dtia_master
  import dtia_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  dtia_if.mst bus,
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic [7:0] req_value,
  output logic req_busy,
  output logic done,
  output logic [7:0] rd_value,
  output logic irq
);
  typedef enum logic [1:0] {M_IDLE, M_ISSUE, M_WAIT} dtia_mst_t;
  dtia_mst_t st_ff, nxt_st;
  logic [3:0] step_ff, nxt_step;
  logic rd_ff, nxt_rd;
  logic [7:0] val_ff, nxt_val;
  logic done_ff, nxt_done;
  logic [7:0] rdv_ff, nxt_rdv;
  logic [2:0] irq_sync_ff;
  logic irq_ff;
  logic cv_ff, nxt_cv;
  dtia_kind_t kind_ff, nxt_kind;
  logic [5:0] ca_ff, nxt_ca;
  logic [3:0] cn_ff, nxt_cn;
  logic [3:0] last;
  logic busy_ff, nxt_busy;

  always_comb begin
    nxt_st = st_ff;
    nxt_step = step_ff;
    nxt_rd = rd_ff;
    nxt_val = val_ff;
    nxt_done = 1'b0;
    nxt_rdv = rdv_ff;
    nxt_cv = 1'b0;
    nxt_kind = kind_ff;
    nxt_ca = ca_ff;
    nxt_cn = cn_ff;
    last = rd_ff ? 4'h6 : 4'h8;
    case (st_ff)
      M_IDLE: if (req_valid) begin // [RL2] [RL5] [RL7] [RL8]
        nxt_rd = req_read;
        nxt_val = req_value;
        nxt_step = 4'h0;
        nxt_st = M_ISSUE;
      end
      M_ISSUE: if (bus.ready) begin // [RL14]
        nxt_cv = 1'b1;
        nxt_st = M_WAIT;
        nxt_kind = DTIA_KIND_WDATA;
        case (step_ff)
          4'h0: begin nxt_kind = DTIA_KIND_ADDR;
            nxt_ca = DTIA_CMD_ADDR_LO; end // [RL10]
          4'h1: nxt_cn = DTIA_TOG_ADDR[7:4];
          4'h2: nxt_cn = DTIA_TOG_ADDR[3:0];
          4'h3: begin nxt_kind = DTIA_KIND_ADDR;
            nxt_ca = DTIA_CMD_ADDR_HI; end // [RL11]
          4'h4: nxt_cn = DTIA_TOG_ADDR[15:12]; // [RL9]
          4'h5: nxt_cn = DTIA_TOG_ADDR[11:8];
          4'h6: begin
            nxt_kind = rd_ff ? DTIA_KIND_READ : DTIA_KIND_ADDR; // [RL13]
            nxt_ca = DTIA_CMD_VALUE; end // [RL12]
          4'h7: nxt_cn = val_ff[7:4];
          default: nxt_cn = val_ff[3:0];
        endcase
      end
      default: if (!bus.ready && !cv_ff) begin
        if (bus.rd_valid) begin
          nxt_rdv = bus.rd_data;
        end
        if (step_ff == last) begin
          nxt_done = 1'b1;
          nxt_st = M_IDLE;
        end else begin
          nxt_step = step_ff + 4'h1;
          nxt_st = M_ISSUE;
        end
      end
    endcase
    nxt_busy = (nxt_st != M_IDLE);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= M_IDLE;
      step_ff <= 4'h0;
      rd_ff <= 1'b0;
      val_ff <= 8'h00;
      done_ff <= 1'b0;
      rdv_ff <= 8'h00;
      irq_sync_ff <= 3'b111;
      irq_ff <= 1'b0;
      cv_ff <= 1'b0;
      kind_ff <= DTIA_KIND_ADDR;
      ca_ff <= 6'h00;
      cn_ff <= 4'h0;
      busy_ff <= 1'b0;
    end else if (ce) begin
      busy_ff <= nxt_busy;
      st_ff <= nxt_st;
      step_ff <= nxt_step;
      rd_ff <= nxt_rd;
      val_ff <= nxt_val;
      done_ff <= nxt_done;
      rdv_ff <= nxt_rdv;
      irq_sync_ff <= {irq_sync_ff[1:0], bus.int_n};
      if (irq_sync_ff[2] == irq_sync_ff[1]) begin
        irq_ff <= ~irq_sync_ff[1]; // [RL15]
      end
      cv_ff <= nxt_cv;
      kind_ff <= nxt_kind;
      ca_ff <= nxt_ca;
      cn_ff <= nxt_cn;
    end
  end

  assign bus.cmd_valid = cv_ff;
  assign bus.cmd_kind = kind_ff;
  assign bus.cmd_addr = ca_ff;
  assign bus.cmd_nibble = cn_ff;
  assign req_busy = busy_ff;
  assign done = done_ff;
  assign rd_value = rdv_ff;
  assign irq = irq_ff;
endmodule // dtia_master

// *** bench/dtia_monitor.sv ***
`timescale 1ns/1ps
module dtia_monitor
  import dtia_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire dtia_kind_t cmd_kind,
  input wire logic [5:0] cmd_addr,
  input wire logic [3:0] cmd_nibble,
  input wire logic ready,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic int_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_RDY_WIN: assert property (
    cmd_valid && ready |=> !ready [*3] ##1 ready)
    else $error("ready window wrong");
  AST_CMD_RDY: assert property (cmd_valid |-> ready)
    else $error("command while not ready");
  AST_RD_ANS: assert property (cmd_valid && ready &&
    cmd_kind == DTIA_KIND_READ |=> rd_valid) else $error("no read answer");
  AST_RD_PULSE: assert property (rd_valid |=> !rd_valid)
    else $error("read answer too long");
  AST_RD_FMT: assert property (rd_valid |-> rd_data[6:5] == 2'h0)
    else $error("set bits read back");
  AST_RST: assert property ($rose(nrst) |-> !ready && int_n)
    else $error("outputs not at default");
  AST_LO_NIB: assert property (
    cmd_valid && cmd_kind == DTIA_KIND_ADDR &&
    cmd_addr == DTIA_CMD_ADDR_LO |->
    ##[1:12] cmd_valid && cmd_nibble == 4'h8)
    else $error("low address nibble wrong");
  AST_HI_NIB: assert property (
    cmd_valid && cmd_kind == DTIA_KIND_ADDR &&
    cmd_addr == DTIA_CMD_ADDR_HI |->
    ##[1:12] cmd_valid && cmd_nibble == 4'he)
    else $error("high address nibble wrong");
endmodule // dtia_monitor

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench import dtia_pkg::*;;
  localparam logic [3:0] EPS [5] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h8};
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, sfr = 1'b0, rv = 1'b0, rr = 1'b0;
  logic [7:0] val = 8'h00, s, rdv;
  logic busy, done, irq;
  logic [31:0] tog;
  int n_errors = 0, n_tests = 0;
  dtia_if bus_if();
  dtia_device i_dtia_device(.clk(clk), .nrst(nrst), .ce(ce), .bus(bus_if),
    .setup_feature_req(sfr), .toggle_bits(tog));
  dtia_master i_dtia_master(.clk(clk), .nrst(nrst), .ce(ce), .bus(bus_if),
    .req_valid(rv), .req_read(rr), .req_value(val), .req_busy(busy),
    .done(done), .rd_value(rdv), .irq(irq));
  dtia_monitor i_mon(.clk(clk), .nrst(nrst), .cmd_valid(bus_if.cmd_valid),
    .cmd_kind(bus_if.cmd_kind), .cmd_addr(bus_if.cmd_addr),
    .cmd_nibble(bus_if.cmd_nibble), .ready(bus_if.ready),
    .rd_valid(bus_if.rd_valid), .rd_data(bus_if.rd_data),
    .int_n(bus_if.int_n));
  always #2.5 clk = ~clk;
  task wrap_up;
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Full indirect sequence through the master, bounded wait on done
  task xfer(input logic rd, input logic [7:0] v);
    int k;
    k = 0;
    rr <= rd;
    val <= v;
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    while (done !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    if (k == 200) n_errors++;
  endtask
  task rd(input logic [7:0] e);
    xfer(1'b1, 8'h00);
    chk(rdv, e);
    chk({7'h0, busy}, 8'h00);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h12);
    foreach (EPS[i]) for (int d = 0; d < 2; d++) begin
      s = {3'h0, d[0], EPS[i]};
      xfer(1'b0, s);
      xfer(1'b0, s | 8'h40);
      rd(s | 8'h80);
      chk({7'h0, tog[s[4:0]]}, 8'h01);
      xfer(1'b0, s | 8'h20);
      rd(s);
    end
    xfer(1'b0, 8'h76);
    rd(8'h96);
    xfer(1'b0, 8'h06);
    rd(8'h06);
    sfr <= 1'b1;
    repeat (6) @(posedge clk);
    chk({6'h0, irq, bus_if.int_n}, 8'h02);
    sfr <= 1'b0;
    repeat (6) @(posedge clk);
    chk({6'h0, irq, bus_if.int_n}, 8'h01);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h12);
    xfer(1'b0, 8'h16);
    rd(8'h16);
    wrap_up;
  end
  initial begin
    repeat (8000) @(posedge clk);
    n_errors++;
    wrap_up;
  end
endmodule // testbench
